// >>> bench/jcl_host.sv
// Host programmer model driving the scan port
`timescale 1ns/1ps
module jcl_host (
	output logic tck,
	output logic trst_n,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial begin
		tck = 1'h0;
		trst_n = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
	end
	// One scan clock, tdo read just before the rise
	task automatic cyc(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#32;
		q = tdo;
		tck = 1'h1;
		#32;
		tck = 1'h0;
	endtask
	task automatic go_idle();
		logic q;
		trst_n = 1'h0;
		repeat (4) cyc(1'h1, 1'h0, q);
		trst_n = 1'h1;
		repeat (5) cyc(1'h1, 1'h0, q);
		cyc(1'h0, 1'h0, q);
	endtask
	// Idle to idle through one scan, lsb first
	task automatic scan(input logic ir, input int n, input logic [31:0] d,
		output logic [31:0] o);
		logic q;
		o = '0;
		cyc(1'h1, 1'h0, q);
		if (ir) begin
			cyc(1'h1, 1'h0, q);
		end
		cyc(1'h0, 1'h0, q);
		cyc(1'h0, 1'h0, q);
		for (int i = 0; i < n; i++) begin
			cyc(i == n - 1, d[i], o[i]);
		end
		cyc(1'h1, 1'h0, q);
		cyc(1'h0, 1'h0, q);
		tdi = ~tdi;
	endtask
endmodule

// >>> bench/jcl_monitor.sv
// Port checker for the configuration loader
`timescale 1ns/1ps
module jcl_monitor (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tms,
	input wire logic tdo_oe,
	input wire logic config_complete_flag_o,
	input wire logic config_complete_flag_oe,
	input wire logic config_status_low_on_error_o,
	input wire logic config_status_low_on_error_oe,
	input wire logic config_busy,
	input wire logic config_failed
);
	a_reset_quiet: assert property (@(posedge clk_sys) !rstn |=> config_complete_flag_oe
		&& !config_status_low_on_error_oe && !config_busy && !config_failed)
		else $error("loader outputs not quiet after reset");
	a_fail_status: assert property (@(posedge clk_sys) disable iff (!rstn)
		config_failed == config_status_low_on_error_oe)
		else $error("status line disagrees with failure");
	a_pins_low: assert property (@(posedge clk_sys) disable iff (!rstn)
		config_complete_flag_o == 1'h0 && config_status_low_on_error_o == 1'h0)
		else $error("open-drain pin driven high");
	a_done_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
		!config_complete_flag_oe |-> !config_busy && !config_failed)
		else $error("done released while busy or failed");
	a_busy_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
		config_busy |-> config_complete_flag_oe)
		else $error("done released during loading");
	a_done_after: assert property (@(posedge clk_sys) disable iff (!rstn)
		$fell(config_complete_flag_oe) |-> $past(config_busy))
		else $error("done released without a check");
	a_oe_leaves: assert property (@(posedge tck) disable iff (!trst_n)
		$past(tms) |-> !tdo_oe)
		else $error("output enable held outside shift");
	a_oe_enters: assert property (@(posedge tck) disable iff (!trst_n)
		$rose(tdo_oe) |-> !$past(tms) && !$past(tms, 2))
		else $error("output enable without capture and shift");
endmodule

bind jcl_top jcl_monitor u_mon (
	.clk_sys, .rstn, .tck, .trst_n, .tms, .tdo_oe, .config_complete_flag_o,
	.config_complete_flag_oe, .config_status_low_on_error_o,
	.config_status_low_on_error_oe, .config_busy, .config_failed
);

// >>> bench/jcl_top_tb.sv
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
module jcl_top_tb;
	logic clk_sys, rstn, tck, trst_n, tms, tdi, tdo, tdo_oe, tdo_w, done_wire;
	logic ce_low, req_low, clr_low, out_en, done_oe, st_oe, busy, failed;
	int err_total;
	int checks;
	logic [31:0] o;

	assign done_wire = done_oe ? 1'h0 : 1'h1;
	assign tdo_w = tdo_oe ? tdo : 1'h1;

	jcl_top #(.CFG_BYTES(4)) u_dut (
		.clk_sys(clk_sys), .rstn(rstn), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .chip_enable_low(ce_low), .config_request_low(req_low),
		.dev_clear_low(clr_low), .dev_out_enable(out_en),
		.config_complete_flag_i(done_wire), .config_complete_flag_o(),
		.config_complete_flag_oe(done_oe), .config_status_low_on_error_o(),
		.config_status_low_on_error_oe(st_oe), .config_busy(busy), .config_failed(failed)
	);
	jcl_host u_host (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo_w));

	initial begin
		clk_sys = 1'h0;
		forever #10 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] flags();
		return {28'h0, done_oe, st_oe, busy, failed};
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d, errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wait_fl(input logic [3:0] v);
		int n;
		n = 0;
		while (flags() !== {28'h0, v} && n < 500) begin
			@(negedge clk_sys);
			n++;
		end
		if (flags() !== {28'h0, v}) begin
			err_total++;
			$display("unexpected flags: expected %h, seen %h", v, flags());
			stop_test();
		end
		chk("loader flags", {28'h0, v}, flags());
	endtask
	task automatic pins(input logic [3:0] v);
		@(posedge clk_sys);
		{ce_low, req_low, clr_low, out_en} <= v;
	endtask
	task automatic ir(input logic [3:0] c);
		u_host.scan(1'h1, 4, {28'h0, c}, o);
		chk("ir capture", 32'h1, o);
	endtask
	task automatic t_bypass();
		pins(4'h5);
		ir(jcl_pkg::IR_BYPASS);
		u_host.scan(1'h0, 8, 32'hb6, o);
		chk("bypass echo", 32'h6c, o);
	endtask
	task automatic t_sample();
		ir(jcl_pkg::IR_SAMPLE);
		u_host.scan(1'h0, 2, 32'h0, o);
		chk("sample", 32'h2, o);
	endtask
	task automatic t_cfg(input logic [7:0] fix, input logic [2:0] st, input logic [3:0] fl);
		logic [31:0] img;
		img = {8'h3c ^ 8'ha5 ^ 8'h0f ^ fix, 8'h0f, 8'ha5, 8'h3c};
		ir(jcl_pkg::IR_CONFIG);
		u_host.scan(1'h0, 32, img, o);
		chk("config echo", {img[30:0], 1'h0}, o);
		wait_fl(fl);
		ir(jcl_pkg::IR_STATUS);
		u_host.scan(1'h0, 3, 32'h0, o);
		chk("status scan", {29'h0, st}, o);
	endtask
	task automatic t_abort();
		pins(4'h0);
		wait_fl(4'h8);
		pins(4'h4);
	endtask
	task automatic t_refuse();
		pins(4'h7);
		ir(jcl_pkg::IR_CONFIG);
		u_host.scan(1'h0, 16, 32'h1234, o);
		wait_fl(4'ha);
		ir(jcl_pkg::IR_SAMPLE);
		u_host.scan(1'h0, 2, 32'h1, o);
		chk("refused sample", 32'h2, o);
		t_abort();
	endtask
	task automatic t_ce();
		pins(4'hc);
		ir(jcl_pkg::IR_CONFIG);
		wait_fl(4'hd);
		pins(4'h4);
	endtask
	// Idle loader never drains, so the ninth byte overflows
	task automatic t_over();
		pins(4'h0);
		wait_fl(4'h8);
		ir(jcl_pkg::IR_CONFIG);
		pins(4'h4);
		repeat (3) u_host.scan(1'h0, 32, 32'h5a5a5a5a, o);
		wait_fl(4'hd);
	endtask

	initial begin
		err_total = 0;
		checks = 0;
		rstn = 1'h0;
		{ce_low, req_low, clr_low, out_en} = 4'h4;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'h1;
		@(negedge clk_sys);
		chk("reset flags", 32'h8, flags());
		u_host.go_idle();
		t_bypass();
		t_sample();
		t_cfg(8'h01, 3'h2, 4'hd);
		t_cfg(8'h00, 3'h1, 4'h0);
		t_abort();
		t_refuse();
		t_ce();
		t_over();
		stop_test();
	end
endmodule

// >>> rtl/jcl_fifo.sv
// Dual-clock FIFO with gray-coded pointers
`timescale 1ns/1ps
module jcl_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic wr_clk,
	input wire logic wr_rst_n,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [W-1:0] wr_data,
	input wire logic rd_clk,
	input wire logic rd_rst_n,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [W-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_bin;
	logic [AW:0] wr_gray;
	logic [AW:0] rd_bin;
	logic [AW:0] rd_gray;
	logic [AW:0] rd_gray_w;
	logic [AW:0] wr_gray_r;
	logic [AW:0] next_wr_bin;
	logic [AW:0] next_rd_bin;

	assign next_wr_bin = wr_bin + (AW+1)'(1);
	assign next_rd_bin = rd_bin + (AW+1)'(1);
	// Full when gray pointers differ only in the top two bits
	assign wr_ready = (wr_gray != {~rd_gray_w[AW:AW-1], rd_gray_w[AW-2:0]});
	assign rd_valid = (rd_gray != wr_gray_r);
	assign rd_data = mem[rd_bin[AW-1:0]];

	always_ff @(posedge wr_clk) begin
		if (!wr_rst_n) begin
			wr_bin <= '0;
			wr_gray <= '0;
		end else if (wr_valid && wr_ready) begin
			mem[wr_bin[AW-1:0]] <= wr_data;
			wr_bin <= next_wr_bin;
			wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
		end
	end

	always_ff @(posedge rd_clk) begin
		if (!rd_rst_n) begin
			rd_bin <= '0;
			rd_gray <= '0;
		end else if (rd_valid && rd_ready) begin
			rd_bin <= next_rd_bin;
			rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
		end
	end

	jcl_sync #(.W(AW+1)) u_rd2wr (
		.clk(wr_clk),
		.rst_n(wr_rst_n),
		.d(rd_gray),
		.q(rd_gray_w)
	);

	jcl_sync #(.W(AW+1)) u_wr2rd (
		.clk(rd_clk),
		.rst_n(rd_rst_n),
		.d(wr_gray),
		.q(wr_gray_r)
	);
endmodule

// >>> rtl/jcl_pkg.sv
// Shared constants and types for the scan-port configuration loader
package jcl_pkg;

	// Instruction register
	localparam int IR_W = 4;
	localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
	localparam logic [IR_W-1:0] IR_SAMPLE = 4'h5;
	localparam logic [IR_W-1:0] IR_CONFIG = 4'h2;
	localparam logic [IR_W-1:0] IR_STATUS = 4'h3;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

	// Data paths
	localparam int BYTE_W = 8;
	localparam int BIT_CNT_W = 3;
	localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
	localparam int FIFO_DEPTH = 8;
	localparam int BSR_W = 2;
	localparam int STAT_W = 3;
	localparam int CFG_BYTES_DEF = 16;

	// Reset values
	localparam logic BIT_RST = 1'h0;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
		TAP_PA_DR, TAP_EX2_DR, TAP_UP_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
		TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UP_IR
	} jcl_tap_t;

	typedef enum logic [2:0] {
		CFG_IDLE, CFG_LOAD, CFG_WRITE, CFG_CHECK, CFG_DONE, CFG_FAIL
	} jcl_cfg_t;

	// Scan side to system side levels
	typedef struct packed {
		logic cfg_sel;
		logic overflow;
	} jcl_tap_flags_t;

	// System side to scan side levels
	typedef struct packed {
		logic busy;
		logic fail;
		logic done_pin;
	} jcl_sys_flags_t;

	// Board strap levels
	typedef struct packed {
		logic chip_enable_low;
		logic config_request_low;
	} jcl_strap_t;

endpackage

// >>> rtl/jcl_sync.sv
// Two-flop level synchroniser, one lane per bit
`timescale 1ns/1ps
module jcl_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_lane
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					meta[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta[i] <= d[i];
					q[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule

// >>> rtl/jcl_top.sv
// Scan-port configuration loader: test access port, loader and status pins
// Operation
// - Bypass is one bit, no internal effect
// - Config data reaches test output one cycle later
// - Scan pins are dedicated, never user pins
// - No boundary test while configuration runs
// - Device reset and enable only sampled
// - Error pulls open-drain status low
// - Success releases the done output high
// - Sample inputs rising edge, output falling edge
`timescale 1ns/1ps
module jcl_top #(
	parameter int CFG_BYTES = jcl_pkg::CFG_BYTES_DEF
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic chip_enable_low,
	input wire logic config_request_low,
	input wire logic dev_clear_low,
	input wire logic dev_out_enable,
	input wire logic config_complete_flag_i,
	output logic config_complete_flag_o,
	output logic config_complete_flag_oe,
	output logic config_status_low_on_error_o,
	output logic config_status_low_on_error_oe,
	output logic config_busy,
	output logic config_failed
);
	localparam int CW = $clog2(CFG_BYTES);
	localparam logic [CW-1:0] CNT_LAST = CW'(CFG_BYTES - 1);

	// Scan clock domain
	jcl_pkg::jcl_tap_t tap;
	jcl_pkg::jcl_tap_t next_tap;
	logic [jcl_pkg::IR_W-1:0] ir;
	logic [jcl_pkg::IR_W-1:0] ir_sh;
	logic [jcl_pkg::IR_W-1:0] ir_eff;
	logic dr_bit;
	logic [jcl_pkg::BSR_W-1:0] bsr;
	logic [jcl_pkg::STAT_W-1:0] stat_sh;
	logic [jcl_pkg::BYTE_W-1:0] byte_sh;
	logic [jcl_pkg::BIT_CNT_W-1:0] bit_cnt;
	logic push;
	logic push_ready;
	jcl_pkg::jcl_tap_flags_t tap_flags;
	jcl_pkg::jcl_sys_flags_t sys_flags_t;
	jcl_pkg::jcl_sys_flags_t sys_flags;
	logic [jcl_pkg::BSR_W-1:0] pins_t;

	// System clock domain
	jcl_pkg::jcl_cfg_t cfg;
	jcl_pkg::jcl_tap_flags_t tap_flags_s;
	jcl_pkg::jcl_strap_t strap;
	jcl_pkg::jcl_strap_t strap_s;
	logic done_pin_s;
	logic sel_prev;
	logic [CW-1:0] cnt;
	logic [jcl_pkg::BYTE_W-1:0] xor_acc;
	logic [jcl_pkg::BYTE_W-1:0] hold;
	logic [jcl_pkg::BYTE_W-1:0] mem [CFG_BYTES];
	logic pop_valid;
	logic pop_ready;
	logic [jcl_pkg::BYTE_W-1:0] pop_data;
	logic start;

	// Scan-port state machine; pins stay scan pins in every mode
	always_comb begin
		case (tap)
			jcl_pkg::TAP_RESET: next_tap = tms ? jcl_pkg::TAP_RESET : jcl_pkg::TAP_IDLE;
			jcl_pkg::TAP_IDLE: next_tap = tms ? jcl_pkg::TAP_SEL_DR : jcl_pkg::TAP_IDLE;
			jcl_pkg::TAP_SEL_DR: next_tap = tms ? jcl_pkg::TAP_SEL_IR : jcl_pkg::TAP_CAP_DR;
			jcl_pkg::TAP_CAP_DR: next_tap = tms ? jcl_pkg::TAP_EX1_DR : jcl_pkg::TAP_SH_DR;
			jcl_pkg::TAP_SH_DR: next_tap = tms ? jcl_pkg::TAP_EX1_DR : jcl_pkg::TAP_SH_DR;
			jcl_pkg::TAP_EX1_DR: next_tap = tms ? jcl_pkg::TAP_UP_DR : jcl_pkg::TAP_PA_DR;
			jcl_pkg::TAP_PA_DR: next_tap = tms ? jcl_pkg::TAP_EX2_DR : jcl_pkg::TAP_PA_DR;
			jcl_pkg::TAP_EX2_DR: next_tap = tms ? jcl_pkg::TAP_UP_DR : jcl_pkg::TAP_SH_DR;
			jcl_pkg::TAP_UP_DR: next_tap = tms ? jcl_pkg::TAP_SEL_DR : jcl_pkg::TAP_IDLE;
			jcl_pkg::TAP_SEL_IR: next_tap = tms ? jcl_pkg::TAP_RESET : jcl_pkg::TAP_CAP_IR;
			jcl_pkg::TAP_CAP_IR: next_tap = tms ? jcl_pkg::TAP_EX1_IR : jcl_pkg::TAP_SH_IR;
			jcl_pkg::TAP_SH_IR: next_tap = tms ? jcl_pkg::TAP_EX1_IR : jcl_pkg::TAP_SH_IR;
			jcl_pkg::TAP_EX1_IR: next_tap = tms ? jcl_pkg::TAP_UP_IR : jcl_pkg::TAP_PA_IR;
			jcl_pkg::TAP_PA_IR: next_tap = tms ? jcl_pkg::TAP_EX2_IR : jcl_pkg::TAP_PA_IR;
			jcl_pkg::TAP_EX2_IR: next_tap = tms ? jcl_pkg::TAP_UP_IR : jcl_pkg::TAP_SH_IR;
			jcl_pkg::TAP_UP_IR: next_tap = tms ? jcl_pkg::TAP_SEL_DR : jcl_pkg::TAP_IDLE;
			default: next_tap = jcl_pkg::TAP_RESET;
		endcase
	end

	// Controller steps on rising scan clock only
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tap <= jcl_pkg::TAP_RESET;
		end else begin
			tap <= next_tap;
		end
	end

	// Instruction register
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir <= jcl_pkg::IR_BYPASS;
			ir_sh <= jcl_pkg::IR_CAPTURE;
		end else begin
			case (tap)
				jcl_pkg::TAP_RESET: ir <= jcl_pkg::IR_BYPASS;
				jcl_pkg::TAP_CAP_IR: ir_sh <= jcl_pkg::IR_CAPTURE;
				jcl_pkg::TAP_SH_IR: ir_sh <= {tdi, ir_sh[jcl_pkg::IR_W-1:1]};
				jcl_pkg::TAP_UP_IR: ir <= ir_sh;
				default: ir <= ir;
			endcase
		end
	end

	// Boundary test refused while configuration is running
	always_comb begin
		ir_eff = ir;
		if (ir == jcl_pkg::IR_SAMPLE && sys_flags.busy) begin
			ir_eff = jcl_pkg::IR_BYPASS;
		end
	end

	// One-bit stage for bypass and configuration data
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			dr_bit <= jcl_pkg::BIT_RST;
		end else if (tap == jcl_pkg::TAP_CAP_DR) begin
			dr_bit <= jcl_pkg::BIT_RST;
		end else if (tap == jcl_pkg::TAP_SH_DR) begin
			dr_bit <= tdi;
		end
	end

	// Boundary sample and status registers
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			bsr <= '0;
			stat_sh <= '0;
		end else if (tap == jcl_pkg::TAP_CAP_DR) begin
			bsr <= pins_t;
			stat_sh <= sys_flags;
		end else if (tap == jcl_pkg::TAP_SH_DR) begin
			if (ir_eff == jcl_pkg::IR_SAMPLE) begin
				bsr <= {tdi, bsr[jcl_pkg::BSR_W-1:1]};
			end
			if (ir_eff == jcl_pkg::IR_STATUS) begin
				stat_sh <= {tdi, stat_sh[jcl_pkg::STAT_W-1:1]};
			end
		end
	end

	// Byte assembly of configuration data, first bit is the byte lsb
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			byte_sh <= jcl_pkg::BYTE_RST;
			bit_cnt <= '0;
			push <= 1'b0;
		end else begin
			push <= 1'b0;
			if (tap == jcl_pkg::TAP_UP_IR) begin
				bit_cnt <= '0;
			end else if (tap == jcl_pkg::TAP_SH_DR && ir == jcl_pkg::IR_CONFIG) begin
				byte_sh <= {tdi, byte_sh[jcl_pkg::BYTE_W-1:1]};
				bit_cnt <= bit_cnt + jcl_pkg::BIT_CNT_W'(1);
				push <= (bit_cnt == jcl_pkg::BIT_LAST);
			end
		end
	end

	// Selection and overflow levels toward the loader
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tap_flags <= '0;
		end else begin
			if (tap == jcl_pkg::TAP_RESET || tap == jcl_pkg::TAP_UP_IR) begin
				tap_flags.cfg_sel <= (tap == jcl_pkg::TAP_UP_IR) && (ir_sh == jcl_pkg::IR_CONFIG);
			end
			if (tap == jcl_pkg::TAP_UP_IR && ir_sh == jcl_pkg::IR_CONFIG) begin
				tap_flags.overflow <= 1'b0;
			end else if (push && !push_ready) begin
				tap_flags.overflow <= 1'b1;
			end
		end
	end

	// Test output changes on the falling scan clock
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo_oe <= (tap == jcl_pkg::TAP_SH_DR) || (tap == jcl_pkg::TAP_SH_IR);
			if (tap == jcl_pkg::TAP_SH_IR) begin
				tdo <= ir_sh[0];
			end else begin
				case (ir_eff)
					jcl_pkg::IR_SAMPLE: tdo <= bsr[0];
					jcl_pkg::IR_STATUS: tdo <= stat_sh[0];
					default: tdo <= dr_bit;
				endcase
			end
		end
	end

	jcl_sync #(.W(jcl_pkg::BSR_W)) u_pins_t (
		.clk(tck),
		.rst_n(trst_n),
		.d({dev_out_enable, dev_clear_low}),
		.q(pins_t)
	);

	jcl_sync #(.W(jcl_pkg::STAT_W)) u_sys2tck (
		.clk(tck),
		.rst_n(trst_n),
		.d(sys_flags_t),
		.q(sys_flags)
	);

	jcl_fifo #(.W(jcl_pkg::BYTE_W), .DEPTH(jcl_pkg::FIFO_DEPTH)) u_fifo (
		.wr_clk(tck),
		.wr_rst_n(trst_n),
		.wr_valid(push),
		.wr_ready(push_ready),
		.wr_data(byte_sh),
		.rd_clk(clk_sys),
		.rd_rst_n(rstn),
		.rd_valid(pop_valid),
		.rd_ready(pop_ready),
		.rd_data(pop_data)
	);

	// System side: crossing of scan levels, straps and done pin
	jcl_sync #(.W(2)) u_tck2sys (
		.clk(clk_sys),
		.rst_n(rstn),
		.d(tap_flags),
		.q(tap_flags_s)
	);

	assign strap.chip_enable_low = chip_enable_low;
	assign strap.config_request_low = config_request_low;

	jcl_sync #(.W(2)) u_strap (
		.clk(clk_sys),
		.rst_n(rstn),
		.d(strap),
		.q(strap_s)
	);

	jcl_sync #(.W(1)) u_done_pin (
		.clk(clk_sys),
		.rst_n(rstn),
		.d(config_complete_flag_i),
		.q(done_pin_s)
	);

	assign start = tap_flags_s.cfg_sel && !sel_prev;
	assign pop_ready = (cfg == jcl_pkg::CFG_LOAD);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sel_prev <= 1'b0;
		end else begin
			sel_prev <= tap_flags_s.cfg_sel;
		end
	end

	// Loader sequence
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cfg <= jcl_pkg::CFG_IDLE;
		end else if (!strap_s.config_request_low) begin
			cfg <= jcl_pkg::CFG_IDLE;
		end else if (start) begin
			cfg <= strap_s.chip_enable_low ? jcl_pkg::CFG_FAIL : jcl_pkg::CFG_LOAD;
		end else if (tap_flags_s.overflow && cfg != jcl_pkg::CFG_DONE) begin
			cfg <= jcl_pkg::CFG_FAIL;
		end else begin
			case (cfg)
				jcl_pkg::CFG_LOAD: begin
					if (pop_valid) begin
						cfg <= jcl_pkg::CFG_WRITE;
					end
				end
				jcl_pkg::CFG_WRITE: begin
					cfg <= (cnt == CNT_LAST) ? jcl_pkg::CFG_CHECK : jcl_pkg::CFG_LOAD;
				end
				jcl_pkg::CFG_CHECK: begin
					cfg <= (mem[CNT_LAST] == xor_acc) ? jcl_pkg::CFG_DONE : jcl_pkg::CFG_FAIL;
				end
				default: cfg <= cfg;
			endcase
		end
	end

	// Data store and running check
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cnt <= '0;
			xor_acc <= jcl_pkg::BYTE_RST;
			hold <= jcl_pkg::BYTE_RST;
		end else if (start) begin
			cnt <= '0;
			xor_acc <= jcl_pkg::BYTE_RST;
		end else if (cfg == jcl_pkg::CFG_LOAD && pop_valid) begin
			hold <= pop_data;
		end else if (cfg == jcl_pkg::CFG_WRITE) begin
			mem[cnt] <= hold;
			cnt <= cnt + CW'(1);
			if (cnt != CNT_LAST) begin
				xor_acc <= xor_acc ^ hold;
			end
		end
	end

	// Open-drain status and done pins, plus status ports
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			config_complete_flag_o <= 1'b0;
			config_complete_flag_oe <= 1'b1;
			config_status_low_on_error_o <= 1'b0;
			config_status_low_on_error_oe <= 1'b0;
			config_busy <= 1'b0;
			config_failed <= 1'b0;
			sys_flags_t <= '0;
		end else begin
			config_complete_flag_o <= 1'b0;
			config_complete_flag_oe <= (cfg != jcl_pkg::CFG_DONE);
			config_status_low_on_error_o <= 1'b0;
			config_status_low_on_error_oe <= (cfg == jcl_pkg::CFG_FAIL);
			config_busy <= (cfg == jcl_pkg::CFG_LOAD) || (cfg == jcl_pkg::CFG_WRITE)
				|| (cfg == jcl_pkg::CFG_CHECK);
			config_failed <= (cfg == jcl_pkg::CFG_FAIL);
			sys_flags_t.busy <= (cfg == jcl_pkg::CFG_LOAD) || (cfg == jcl_pkg::CFG_WRITE)
				|| (cfg == jcl_pkg::CFG_CHECK);
			sys_flags_t.fail <= (cfg == jcl_pkg::CFG_FAIL);
			sys_flags_t.done_pin <= done_pin_s;
		end
	end
endmodule
